// ---- logic/tadc_ctrl.sv ----
// Touch ADC serial control, channel decode, conversion sequencing and result path
`include "tadc_map.svh"
`default_nettype none
module tadc_ctrl #(
	parameter int           RES_W   = `TADC_RES_BITS,
	parameter int           DEPTH   = `TADC_FIFO_DEPTH,
	parameter logic [11:0]  ID_CODE = `TADC_ID_CODE
) (
	// System
	input  wire logic                REF_CLK,
	input  wire logic                SRST,
	// Serial port from the host
	input  wire logic                CS_N,
	input  wire logic                CONVERSION_SERIAL_CLOCK,
	input  wire logic                CMD_IN,
	output logic                     DATA_OUT,
	output logic                     DATA_OUT_OE_N,
	output logic                     BUSY,
	output logic                     BUSY_OE_N,
	// Open-drain pen interrupt
	output logic                     PEN_TOUCH_IRQ_O,
	output logic                     PEN_TOUCH_IRQ_OE_N,
	// Analog front end
	input  wire logic                COMP_IN,
	input  wire logic                PEN_TOUCH,
	input  wire logic                DIODE0_SENSE,
	input  wire logic                DIODE1_SENSE,
	output tadc_pkg::tadc_sw_t       SWITCHES,
	output logic                     TRACK,
	output logic [RES_W-1:0]         SAR_TRIAL,
	// Result stream
	output logic                     RESULT_VALID,
	output logic [RES_W-1:0]         RESULT_DATA,
	input  wire logic                RESULT_READY
);
	// ----------------------------------------------------------------
	// Frame timing
	// ----------------------------------------------------------------
	localparam int CW = `TADC_CNT_W;
	localparam logic [CW-1:0] ACQ_START = `TADC_ACQ_START_EDGE;
	localparam logic [CW-1:0] ACQ_END   = `TADC_ACQ_START_EDGE + `TADC_ACQ_EDGES;
	localparam logic [CW-1:0] CONV_END  = ACQ_END + CW'(RES_W);
	localparam logic [CW-1:0] TRAIL_END = CONV_END + `TADC_TRAIL_BITS;
	localparam int ACQ_END_I  = int'(ACQ_END);
	localparam int CONV_END_I = int'(CONV_END);

	typedef struct packed {
		tadc_pkg::tadc_state_t st;
		logic                  sclk_q;
		logic [CW-1:0]         fcnt;
		logic [2:0]            rcnt;
		tadc_pkg::tadc_ctrl_t  ctrl;
		tadc_pkg::tadc_sw_t    sw;
		logic                  track;
		logic                  dout;
		logic                  dout_oe_n;
		logic                  busy;
		logic                  busy_oe_n;
		logic                  pen_oe_n;
		logic                  push;
	} tadc_st_t;

	tadc_st_t           r;
	tadc_st_t           next_r;
	logic               rise;
	logic               fall;
	logic               keep_on;
	logic               sar_start;
	logic               sar_step;
	logic               sar_bit;
	logic               id_mode;
	logic               test0;
	logic               test1;
	logic               fifo_ready;
	logic               drv_off;
	tadc_pkg::tadc_sw_t cfg;
	logic [RES_W-1:0]   trial;

	// ----------------------------------------------------------------
	// Channel decode
	// ----------------------------------------------------------------
	function automatic tadc_pkg::tadc_sw_t decode_sw(input tadc_pkg::tadc_chan_t a, input logic single);
		tadc_pkg::tadc_sw_t s;
		s       = '0;
		s.mux   = a;
		s.ref_p = tadc_pkg::REF_VREF;
		s.ref_n = tadc_pkg::REF_GND;
		case (a)
			tadc_pkg::CH_XPOS: begin
				s.y_drv_p = 1'b1;
				s.y_drv_n = 1'b1;
				if (!single) begin
					s.ref_p = tadc_pkg::REF_YP;
					s.ref_n = tadc_pkg::REF_YN;
				end
			end
			tadc_pkg::CH_PRESS1, tadc_pkg::CH_PRESS2: begin
				s.y_drv_p = 1'b1;
				s.x_drv_n = 1'b1;
				if (!single) begin
					s.ref_p = tadc_pkg::REF_YP;
					s.ref_n = tadc_pkg::REF_XN;
				end
			end
			tadc_pkg::CH_YPOS: begin
				s.x_drv_p = 1'b1;
				s.x_drv_n = 1'b1;
				if (!single) begin
					s.ref_p = tadc_pkg::REF_XP;
					s.ref_n = tadc_pkg::REF_XN;
				end
			end
			default: begin
				s.x_drv_p = 1'b0;
			end
		endcase
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_r        = r;
		next_r.push   = 1'b0;
		next_r.sclk_q = CONVERSION_SERIAL_CLOCK;
		// Serial clock is a synchronous pin; its edges pace the frame states below, while deselect and pen detection act on every REF_CLK cycle
		rise      = CONVERSION_SERIAL_CLOCK && !r.sclk_q;
		fall      = !CONVERSION_SERIAL_CLOCK && r.sclk_q;
		sar_start = 1'b0;
		sar_step  = 1'b0;
		keep_on   = ({r.ctrl.power_ctrl_bit1, r.ctrl.power_ctrl_bit0} == `TADC_KEEP_ON_PD);
		cfg       = decode_sw(r.ctrl.addr, r.ctrl.ref_mode_sel);
		id_mode   = !r.ctrl.ref_mode_sel && (r.ctrl.addr == tadc_pkg::CH_AUX);
		// Test routing waits for the whole control word, else a single-ended frame glitches the pin
		test0     = !r.ctrl.ref_mode_sel && (r.ctrl.addr == tadc_pkg::CH_DIODE0) && (r.st != tadc_pkg::ST_IDLE)
			&& (r.rcnt == `TADC_CTRL_BITS);
		test1     = !r.ctrl.ref_mode_sel && (r.ctrl.addr == tadc_pkg::CH_DIODE1) && (r.st != tadc_pkg::ST_IDLE)
			&& (r.rcnt == `TADC_CTRL_BITS);
		drv_off   = !(r.sw.x_drv_p || r.sw.x_drv_n || r.sw.y_drv_p || r.sw.y_drv_n);
		if (CS_N) begin
			// Deselect aborts any frame and floats both outputs
			next_r.st        = tadc_pkg::ST_IDLE;
			next_r.dout_oe_n = 1'b1;
			next_r.busy_oe_n = 1'b1;
			next_r.busy      = 1'b0;
			next_r.dout      = 1'b0;
			next_r.track     = 1'b0;
			if (!keep_on)
				next_r.sw = '0;
		end else begin
			next_r.dout_oe_n = 1'b0;
			next_r.busy_oe_n = 1'b0;
			case (r.st)
				tadc_pkg::ST_IDLE: begin
					// A full result queue refuses the start bit rather than lose a word
					if (rise && CMD_IN && fifo_ready) begin
						next_r.st   = tadc_pkg::ST_FRAME;
						next_r.fcnt = '0;
						next_r.rcnt = '0;
						next_r.ctrl = '0;
					end
				end
				tadc_pkg::ST_FRAME: begin
					// Reference mode bit lands after tracking starts, so follow it while tracking
					if (r.track)
						next_r.sw = cfg;
					if (rise && (r.rcnt < `TADC_CTRL_BITS)) begin
						next_r.ctrl[3'(`TADC_CTRL_BITS - 3'd1 - r.rcnt)] = CMD_IN;
						next_r.rcnt = r.rcnt + 3'd1;
					end
					if (fall) begin
						next_r.fcnt = r.fcnt + 1'b1;
						if (next_r.fcnt == ACQ_START) begin
							next_r.track = 1'b1;
							next_r.sw    = cfg;
						end
						if (next_r.fcnt == ACQ_END) begin
							next_r.track = 1'b0;
							next_r.busy  = 1'b1;
							next_r.st    = tadc_pkg::ST_CONV;
							sar_start    = 1'b1;
							// Single-ended needs the panel only while tracking
							if (r.ctrl.ref_mode_sel && !keep_on)
								next_r.sw = '0;
							else
								next_r.sw = cfg;
						end
					end
				end
				tadc_pkg::ST_CONV: begin
					if (fall) begin
						next_r.fcnt = r.fcnt + 1'b1;
						sar_step    = 1'b1;
						next_r.dout = sar_bit;
						if (next_r.fcnt == CONV_END) begin
							next_r.busy = 1'b0;
							next_r.push = 1'b1;
							next_r.st   = tadc_pkg::ST_TRAIL;
							if (!keep_on)
								next_r.sw = '0;
						end
					end
				end
				tadc_pkg::ST_TRAIL: begin
					if (fall) begin
						next_r.fcnt = r.fcnt + 1'b1;
						next_r.dout = 1'b0;
						if (next_r.fcnt == TRAIL_END)
							next_r.st = tadc_pkg::ST_IDLE;
					end
				end
				default: begin
					next_r.st = tadc_pkg::ST_IDLE;
				end
			endcase
		end
		// Pen detection only makes sense with the panel drivers released
		if (test0)
			next_r.pen_oe_n = DIODE0_SENSE;
		else if (test1)
			next_r.pen_oe_n = DIODE1_SENSE;
		else
			next_r.pen_oe_n = !(PEN_TOUCH && drv_off);
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			r           <= '0;
			r.dout_oe_n <= 1'b1;
			r.busy_oe_n <= 1'b1;
			r.pen_oe_n  <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Converter and result queue
	// ----------------------------------------------------------------
	tadc_sar #(
		.W          (RES_W)
	) u_sar (
		.clk        (REF_CLK),
		.srst       (SRST),
		.start      (sar_start),
		.step       (sar_step),
		.comp       (COMP_IN),
		.force_en   (id_mode),
		.force_code (ID_CODE),
		.trial      (trial),
		.cur_bit    (sar_bit)
	);

	tadc_fifo #(
		.W          (RES_W),
		.DEPTH      (DEPTH)
	) u_fifo (
		.clk        (REF_CLK),
		.srst       (SRST),
		.in_valid   (r.push),
		.in_data    (trial),
		.in_ready   (fifo_ready),
		.out_valid  (RESULT_VALID),
		.out_data   (RESULT_DATA),
		.out_ready  (RESULT_READY)
	);

	assign DATA_OUT           = r.dout;
	assign DATA_OUT_OE_N      = r.dout_oe_n;
	assign BUSY               = r.busy;
	assign BUSY_OE_N          = r.busy_oe_n;
	assign PEN_TOUCH_IRQ_O    = 1'b0;
	assign PEN_TOUCH_IRQ_OE_N = r.pen_oe_n;
	assign SWITCHES           = r.sw;
	assign TRACK              = r.track;
	assign SAR_TRIAL          = trial;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	sequence s_fifth_fall;
		fall && (r.st == tadc_pkg::ST_FRAME) && (r.fcnt == ACQ_START - 1'b1) && !CS_N;
	endsequence

	sequence s_quiet_cycle;
		!fall && !CS_N && !$past(CS_N);
	endsequence

	deselect_float_a: assert property (CS_N |=> DATA_OUT_OE_N && BUSY_OE_N)
		else $error("outputs driven while deselected");
	dout_fall_only_a: assert property (s_quiet_cycle ##0 (r.st != tadc_pkg::ST_IDLE) |=> $stable(DATA_OUT))
		else $error("data out changed without a falling edge");
	acq_start_a: assert property (s_fifth_fall |=> TRACK ##0 (r.fcnt == ACQ_START))
		else $error("acquisition did not start on fifth falling edge");
	acq_length_a: assert property ($fell(TRACK) && !CS_N |-> (r.fcnt == ACQ_END_I) && BUSY)
		else $error("acquisition did not last three cycles");
	busy_window_a: assert property (BUSY |-> (r.fcnt >= ACQ_END_I) && (r.fcnt < CONV_END_I) && !BUSY_OE_N)
		else $error("busy outside conversion");
	ctrl_capture_a: assert property (rise && !CS_N && (r.st == tadc_pkg::ST_FRAME) && (r.rcnt == 3'd0)
		|=> r.ctrl.addr[2] == $past(CMD_IN))
		else $error("control bit not captured on rising edge");
	start_bit_a: assert property ((r.st == tadc_pkg::ST_IDLE) && rise && CMD_IN && !CS_N && fifo_ready
		|=> (r.st == tadc_pkg::ST_FRAME) && (r.fcnt == '0))
		else $error("start bit not taken");
	pen_open_drain_a: assert property (PEN_TOUCH && drv_off && !test0 && !test1
		|=> !PEN_TOUCH_IRQ_OE_N && !PEN_TOUCH_IRQ_O)
		else $error("pen interrupt not pulled low on touch");
	keep_drivers_a: assert property (keep_on && $past(keep_on) && CS_N && !$past(r.sw == '0) |=> $stable(SWITCHES))
		else $error("drivers dropped while kept on");
endmodule
`default_nettype wire

// ---- common/tadc_map.svh ----
// Timing counts, field positions and fixed codes of the touch ADC control block
`ifndef TADC_MAP_SVH
`define TADC_MAP_SVH

// ----------------------------------------------------------------
// Serial frame timing, in serial-clock edges counted from the start bit
// ----------------------------------------------------------------
`define TADC_ACQ_START_EDGE  5'd5
`define TADC_ACQ_EDGES       5'd3
`define TADC_RES_BITS        12
`define TADC_TRAIL_BITS      5'd3
`define TADC_CTRL_BITS       3'd7
`define TADC_CNT_W           5

// ----------------------------------------------------------------
// Control field layout after the start bit, first bit received first
// ----------------------------------------------------------------
`define TADC_CTRL_ADDR_MSB   6
`define TADC_CTRL_ADDR_LSB   4
`define TADC_CTRL_WIDTH_BIT  3
`define TADC_CTRL_REF_BIT    2
`define TADC_CTRL_PD1_BIT    1
`define TADC_CTRL_PD0_BIT    0

// ----------------------------------------------------------------
// Fixed codes
// ----------------------------------------------------------------
// Identity code returned in its test address; value is arbitrary
`define TADC_ID_CODE         12'h5a3
`define TADC_FIFO_DEPTH      4
`define TADC_KEEP_ON_PD      2'h3

`endif

// ---- common/tadc_pkg.sv ----
// Types shared by the touch ADC control block
`default_nettype none
package tadc_pkg;

	// ----------------------------------------------------------------
	// Frame sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FRAME = 2'b01,
		ST_CONV  = 2'b10,
		ST_TRAIL = 2'b11
	} tadc_state_t;

	// ----------------------------------------------------------------
	// Input channel, equal to the channel address
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CH_DIODE0   = 3'b000,
		CH_XPOS     = 3'b001,
		CH_BATTERY  = 3'b010,
		CH_PRESS1   = 3'b011,
		CH_PRESS2   = 3'b100,
		CH_YPOS     = 3'b101,
		CH_AUX      = 3'b110,
		CH_DIODE1   = 3'b111
	} tadc_chan_t;

	// ----------------------------------------------------------------
	// Reference node sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		REF_VREF = 3'b000,
		REF_GND  = 3'b001,
		REF_XP   = 3'b010,
		REF_XN   = 3'b011,
		REF_YP   = 3'b100,
		REF_YN   = 3'b101
	} tadc_ref_t;

	// ----------------------------------------------------------------
	// Control word: address, width, reference mode, power bits
	// ----------------------------------------------------------------
	typedef struct packed {
		tadc_chan_t addr;
		logic       width8;
		logic       ref_mode_sel;
		logic       power_ctrl_bit1;
		logic       power_ctrl_bit0;
	} tadc_ctrl_t;

	// ----------------------------------------------------------------
	// Analog switch and reference setting
	// ----------------------------------------------------------------
	typedef struct packed {
		tadc_chan_t mux;
		logic       x_drv_p;
		logic       x_drv_n;
		logic       y_drv_p;
		logic       y_drv_n;
		tadc_ref_t  ref_p;
		tadc_ref_t  ref_n;
	} tadc_sw_t;

endpackage
`default_nettype wire

// ---- logic/tadc_fifo.sv ----
// Result FIFO with registered read data and valid/ready on both sides
`default_nettype none
module tadc_fifo #(
	parameter int W     = 12,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// Drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             cnt;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic                    ov;
		logic [W-1:0]            od;
	} tadc_fifo_st_t;

	tadc_fifo_st_t r;
	tadc_fifo_st_t next_r;
	logic          push;
	logic          load;

	always_comb begin
		next_r   = r;
		in_ready = (r.cnt != (AW+1)'(DEPTH));
		push     = in_valid && in_ready;
		// Output register refills whenever it empties or is being taken
		load     = (r.cnt != '0) && (!r.ov || out_ready);
		if (r.ov && out_ready)
			next_r.ov = 1'b0;
		if (load) begin
			next_r.ov = 1'b1;
			next_r.od = r.mem[r.rp];
			next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
		end
		if (push) begin
			next_r.mem[r.wp] = in_data;
			next_r.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
		end
		next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(load);
	end

	always_ff @(posedge clk) begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign out_valid = r.ov;
	assign out_data  = r.od;
endmodule
`default_nettype wire

// ---- logic/tadc_sar.sv ----
// Successive approximation register with a forced-code path
`default_nettype none
module tadc_sar #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Sequencing
	input  wire logic         start,
	input  wire logic         step,
	// Decision source
	input  wire logic         comp,
	input  wire logic         force_en,
	input  wire logic [W-1:0] force_code,
	// Trial code and the bit being decided
	output logic [W-1:0]      trial,
	output logic              cur_bit
);
	localparam int IW = $clog2(W);

	typedef struct packed {
		logic [W-1:0]  trial;
		logic [IW-1:0] idx;
	} tadc_sar_st_t;

	tadc_sar_st_t r;
	tadc_sar_st_t next_r;

	always_comb begin
		next_r  = r;
		// Comparator high means the input lies at or above the trial code
		cur_bit = force_en ? force_code[r.idx] : comp;
		if (start) begin
			next_r.trial = {1'b1, {(W-1){1'b0}}};
			next_r.idx   = IW'(W - 1);
		end else if (step) begin
			next_r.trial[r.idx] = cur_bit;
			if (r.idx != '0) begin
				next_r.trial[r.idx - 1'b1] = 1'b1;
				next_r.idx                 = r.idx - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign trial = r.trial;
endmodule
`default_nettype wire

// ---- verif/tadc_host.sv ----
// Serial host model: frames a command, paces the serial clock and records the replies
`default_nettype none
module tadc_host (
	// System clock the host paces itself by
	input  wire logic               clk,
	// Device replies as seen on the pins
	input  wire logic               dout,
	input  wire logic               busy,
	input  wire logic               track,
	input  wire logic               pen_n,
	input  wire tadc_pkg::tadc_sw_t sw,
	// Serial port drive
	output logic                    cs_n,
	output logic                    sclk,
	output logic                    cmd
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [23:0]        rx;
	logic [23:0]        bz;
	logic [23:0]        tk;
	logic               pen_seen;
	tadc_pkg::tadc_sw_t sw_acq;

	// Clock rests low outside frames; command left high so a start while deselected would show
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		cmd = 1'b1;
	end

	// ----------------------------------------------------------------
	// One frame: lead zeros, start bit, seven control bits, then zeros
	// ----------------------------------------------------------------
	task automatic frame(input logic [6:0] ctl, input int half, input int lead, input int stop);
		@(posedge clk);
		#1 cs_n = 1'b0;
		bz = '0;
		tk = '0;
		for (int k = -lead; k < 24 && k != stop; k++) begin
			cmd = (k == 0) ? 1'b1 : (k > 0 && k < 8) ? ctl[7 - k] : 1'b0;
			repeat (half) @(posedge clk);
			#1 sclk = 1'b1;
			if (k >= 0) begin
				rx[k] = dout;
				bz[k] = busy;
				tk[k] = track;
			end
			if (k == 6) sw_acq = sw;
			if (k == 12) pen_seen = pen_n;
			repeat (half) @(posedge clk);
			#1 sclk = 1'b0;
		end
		repeat (2) @(posedge clk);
		#1 cs_n = 1'b1;
		cmd = 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- verif/tadc_ctrl_test.sv ----
// Self-checking bench for the touch ADC control block
`default_nettype none
module tadc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam logic [11:0] ID = 12'h3c5; // Arbitrary identity value
	logic               ref_clk, srst, comp_in, pen_touch, diode0, diode1, result_ready;
	logic               data_out, data_out_oe_n, busy, busy_oe_n, pen_o, pen_oe_n, track;
	logic               result_valid, cs_n, sclk, cmd;
	logic [11:0]        sar_trial, result_data, vin;
	tadc_pkg::tadc_sw_t switches;
	wire                dout_pin, busy_pin, pen_pin;
	int                 n_errors, checks, cyc;
	int                 seed = 32231;
	logic [11:0]        q[$];

	assign dout_pin = data_out_oe_n ? 1'bz : data_out;
	assign busy_pin = busy_oe_n ? 1'bz : busy;
	assign pen_pin = pen_oe_n ? 1'b1 : pen_o;

	tadc_ctrl #(.ID_CODE(ID)) dut (
		.REF_CLK(ref_clk), .SRST(srst), .CS_N(cs_n), .CONVERSION_SERIAL_CLOCK(sclk), .CMD_IN(cmd),
		.DATA_OUT(data_out), .DATA_OUT_OE_N(data_out_oe_n), .BUSY(busy), .BUSY_OE_N(busy_oe_n),
		.PEN_TOUCH_IRQ_O(pen_o), .PEN_TOUCH_IRQ_OE_N(pen_oe_n), .COMP_IN(comp_in), .PEN_TOUCH(pen_touch),
		.DIODE0_SENSE(diode0), .DIODE1_SENSE(diode1), .SWITCHES(switches), .TRACK(track),
		.SAR_TRIAL(sar_trial), .RESULT_VALID(result_valid), .RESULT_DATA(result_data),
		.RESULT_READY(result_ready)
	);

	tadc_host host (
		.clk(ref_clk), .dout(dout_pin), .busy(busy_pin), .track(track), .pen_n(pen_pin),
		.sw(switches), .cs_n(cs_n), .sclk(sclk), .cmd(cmd)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Ideal comparator; the trial code holds across a serial phase, so one cycle of lag is harmless
	always @(posedge ref_clk) begin
		#1 comp_in = (vin >= sar_trial);
	end

	// ----------------------------------------------------------------
	// Result stream check and hang guard
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
		if (!srst && result_valid === 1'b1 && result_ready) begin
			cmp_vec(24'(result_data), (q.size() > 0) ? 24'(q.pop_front()) : 24'hffffff);
		end
	end

	// ----------------------------------------------------------------
	// Compare tasks, expectations and verdict
	// ----------------------------------------------------------------
	task automatic cmp_vec(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_sw(input tadc_pkg::tadc_sw_t got, input tadc_pkg::tadc_sw_t exp, input logic keep_ref);
		checks++;
		if (!keep_ref) got.ref_p = exp.ref_p;
		if (!keep_ref) got.ref_n = exp.ref_n;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic tadc_pkg::tadc_sw_t exp_sw(input logic [2:0] a, input logic se);
		tadc_pkg::tadc_sw_t s;
		s = '0;
		s.mux = tadc_pkg::tadc_chan_t'(a);
		s.x_drv_p = (a == 3'b101);
		s.x_drv_n = a inside {3'b011, 3'b100, 3'b101};
		s.y_drv_p = a inside {3'b001, 3'b011, 3'b100};
		s.y_drv_n = (a == 3'b001);
		s.ref_p = se ? tadc_pkg::REF_VREF : (a == 3'b101) ? tadc_pkg::REF_XP :
			(a inside {3'b001, 3'b011, 3'b100}) ? tadc_pkg::REF_YP : tadc_pkg::REF_VREF;
		s.ref_n = se ? tadc_pkg::REF_GND : (a == 3'b001) ? tadc_pkg::REF_YN :
			(a inside {3'b011, 3'b100, 3'b101}) ? tadc_pkg::REF_XN : tadc_pkg::REF_GND;
		return s;
	endfunction

	task automatic print_verdict();
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One frame; the result is queued before it can appear and withdrawn if refused or aborted
	task automatic run(input logic [2:0] a, input logic se, input logic [1:0] pd, input int stop, input logic [11:0] v);
		logic [11:0] res;
		logic [14:0] got;
		vin = v;
		res = (!se && a == 3'b110) ? ID : v;
		q.push_back(res);
		host.frame({a, 1'b0, se, pd}, 2 + ($unsigned($random(seed)) % 3), $unsigned($random(seed)) % 3, stop);
		if (host.bz == 24'h0 || stop < 24) begin
			void'(q.pop_back());
		end else begin
			for (int k = 9; k < 24; k++) got = {got[13:0], host.rx[k]};
			cmp_vec(24'(got), 24'({res, 3'b000}));
			cmp_vec(host.bz, 24'h0fff00);
			cmp_vec(host.tk, 24'h0000e0);
			cmp_sw(host.sw_acq, exp_sw(a, se), se || !(a inside {3'b000, 3'b110, 3'b111}));
		end
		repeat (2) @(posedge ref_clk);
		#1;
		cmp_vec(24'({data_out_oe_n, busy_oe_n}), 24'h3);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		pen_touch = 1'b0;
		diode0 = 1'b1;
		diode1 = 1'b1;
		result_ready = 1'b1;
		vin = 12'h000;
		repeat (20) @(posedge ref_clk);
		#1 srst = 1'b0;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 16; i++) run(3'(i), i[3], 2'b00, 99, 12'($random(seed)));
		run(3'b110, 1'b1, 2'b00, 99, 12'hfff);
		run(3'b110, 1'b1, 2'b00, 99, 12'h000);
		run(3'b001, 1'b0, 2'b00, 12, 12'h123);
		run(3'b101, 1'b0, 2'b11, 99, 12'h800);
		cmp_vec(24'({switches.x_drv_p, switches.x_drv_n}), 24'h3);
		run(3'b101, 1'b0, 2'b00, 99, 12'h7ff);
		cmp_vec(24'({switches.x_drv_p, switches.x_drv_n}), 24'h0);
		pen_touch = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		cmp_vec(24'({pen_pin, pen_o}), 24'h0);
		pen_touch = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		cmp_vec(24'(pen_pin), 24'h1);
		for (int d = 0; d < 4; d++) begin
			diode0 = d[0];
			diode1 = d[0];
			run(d[1] ? 3'b111 : 3'b000, 1'b0, 2'b00, 99, 12'(d));
			cmp_vec(24'(host.pen_seen), 24'(d[0]));
		end
		// Consumer stalls until starts are refused, then drains
		result_ready = 1'b0;
		for (int i = 0; i < 6; i++) run(3'b110, 1'b1, 2'b00, 99, 12'($random(seed)));
		cmp_vec(24'(q.size() inside {4, 5}), 24'h1);
		result_ready = 1'b1;
		for (int i = 0; i < 200 && q.size() > 0; i++) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		#1;
		cmp_vec(24'({q.size() == 0, result_valid}), 24'h2);
		print_verdict();
	end
endmodule
`default_nettype wire
